/* File: dv/dls_host_model.sv */
// host model: axi4-lite master that reaches the log sector window
`timescale 1ns/1ps
module dls_host_model (
    input wire logic clock,
    output logic [11:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [11:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial begin
        s_axi_awaddr = 12'h000;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 12'h000;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
    end
    // full-word write of span, flags, pending or revision bytes
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp, output bit hung);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            // released data must not keep looking valid
            if (s_axi_wvalid && s_axi_wready) s_axi_wdata <= ~d;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 100);
        resp = s_axi_bresp;
        hung = !s_axi_bvalid;
        s_axi_bready <= 1'b0;
        // one idle edge so a following call never re-drives ready in the same step
        @(posedge clock);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp, output bit hung);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 100);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        hung = !s_axi_rvalid;
        s_axi_rready <= 1'b0;
        @(posedge clock);
    endtask
endmodule // dls_host_model

/* File: dv/dls_top_bench.sv */
// self-checking bench for the log sector builder
`timescale 1ns/1ps
`include "dls_defs.svh"
module dls_top_bench;
    logic clock, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, err_event, st_issue, st_done;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, err_record, st_fail_lba;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] st_lba_low, st_status, st_checkpoint;
    logic [15:0] power_hours, cur_test_span, sel_flags, sel_pending;
    logic [63:0] cur_test_lba;
    logic [639:0] sel_spans;
    int mismatches = 0;
    int num_checks = 0;
    dls_top #(.NSECT(2)) uut (.*);
    dls_host_model host (.*);
    initial begin
        clock = 1'b0;
        forever begin
            #5 clock = ~clock;
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic hung(input bit h);
        if (h) begin
            mismatches++;
            $display("wrong value bus answer expected 1 seen 0");
            stop_test();
        end
    endtask
    task automatic w32(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        bit h;
        host.wr(a, d, r, h);
        hung(h);
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask
    task automatic r32(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        bit h;
        host.rd(a, d, r, h);
        hung(h);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask
    task automatic cw(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        r32(a, d, `DLS_RESP_OKAY);
        chk($sformatf("word %h", a), e, d);
    endtask
    task automatic cb(input int b, input logic [7:0] e);
        logic [31:0] d;
        r32(12'(b & ~3), d, `DLS_RESP_OKAY);
        chk($sformatf("byte %0d", b), {24'h0, e}, {24'h0, d[8*(b%4)+:8]});
    endtask
    // whole-sector read; slow but it is the only way to see every byte
    task automatic sumchk();
        logic [31:0] d;
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 128; i++) begin
            r32(12'(4 * i), d, `DLS_RESP_OKAY);
            s = s + d[7:0] + d[15:8] + d[23:16] + d[31:24];
        end
        chk("sector sum", 32'h0, {24'h0, s});
    endtask
    task automatic pick(input logic [1:0] l, input logic [5:0] s);
        w32(`DLS_ADDR_SEL, {18'h0, s, 6'h00, l}, `DLS_RESP_OKAY);
    endtask
    task automatic cstat(input logic [7:0] ei, input logic [7:0] si, input logic [15:0] cnt);
        cw(`DLS_ADDR_STATUS, {cnt, si, ei});
    endtask
    function automatic logic [31:0] rec(input int n);
        return {8'hc0, 8'h5a, 8'ha5, 8'(n)};
    endfunction
    task automatic log_err(input logic [31:0] r);
        err_record <= r;
        err_event <= 1'b1;
        @(posedge clock);
        err_event <= 1'b0;
        @(posedge clock);
    endtask
    task automatic centry(input int b, input logic [31:0] r);
        for (int i = 0; i < 4; i++) cb(b + i, r[8*i+:8]);
    endtask
    function automatic logic [71:0] desc(input int t);
        if (t == 0) return 72'h0;
        return {32'h0a0b0c00 + 32'(t), 8'h30 + 8'(t), 16'h0100 + 16'(t), 8'h20 + 8'(t), 8'h10 + 8'(t)};
    endfunction
    // inputs move between issue and done to catch capture at the wrong moment
    task automatic run_st(input int t);
        logic [71:0] v;
        v = desc(t);
        st_lba_low <= v[7:0];
        st_issue <= 1'b1;
        power_hours <= 16'hffff;
        @(posedge clock);
        st_issue <= 1'b0;
        st_lba_low <= ~v[7:0];
        st_status <= v[15:8];
        power_hours <= v[31:16];
        st_checkpoint <= v[39:32];
        st_fail_lba <= v[71:40];
        st_done <= 1'b1;
        @(posedge clock);
        st_done <= 1'b0;
        power_hours <= 16'hffff;
        @(posedge clock);
    endtask
    task automatic cd(input int slot, input int t);
        logic [71:0] v;
        v = desc(t);
        for (int i = 0; i < 9; i++) cb(2 + 24 * slot + i, v[8*i+:8]);
    endtask
    initial begin
        logic [31:0] d;
        sys_rst = 1'b1;
        err_event = 1'b0;
        err_record = 32'h0;
        st_issue = 1'b0;
        st_lba_low = 8'h00;
        st_done = 1'b0;
        st_status = 8'h00;
        st_checkpoint = 8'h00;
        st_fail_lba = 32'h0;
        power_hours = 16'h0000;
        cur_test_lba = 64'h1122334455667788;
        cur_test_span = 16'h0003;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        pick(dls_pkg::DLS_LOG_ERR, 6'h01);
        cw(12'h004, 32'h0);
        pick(dls_pkg::DLS_LOG_ERR, 6'h00);
        cw(12'h000, 32'h00000001);
        cstat(8'h00, 8'h00, 16'h0000);
        sumchk();
        for (int n = 1; n <= 12; n++) begin
            log_err(rec(n));
            cstat(8'((n - 1) % 10 + 1), 8'h00, 16'(n));
            cb(1, 8'((n - 1) % 10 + 1));
            if (n == 1) cb(92, 8'h00);
        end
        centry(2, rec(11));
        centry(92, rec(12));
        centry(182, rec(3));
        cb(452, 8'd12);
        sumchk();
        pick(dls_pkg::DLS_LOG_ERR, 6'h01);
        centry(2, rec(6));
        centry(362, rec(10));
        sumchk();
        pick(dls_pkg::DLS_LOG_ST, 6'h00);
        cw(12'h000, 32'h00000001);
        cb(508, 8'h00);
        for (int t = 1; t <= 22; t++) begin
            run_st(t);
            cstat(8'h02, 8'((t - 1) % 21 + 1), 16'd12);
            if (t == 1) cd(0, 1);
            if (t == 1) cd(1, 0);
            if (t == 21) cd(20, 21);
        end
        cd(0, 22);
        cd(1, 2);
        cb(508, 8'h01);
        sumchk();
        pick(dls_pkg::DLS_LOG_SEL, 6'h00);
        w32(12'h000, 32'h33220001, `DLS_RESP_OKAY);
        w32(12'h050, 32'hddccbbaa, `DLS_RESP_OKAY);
        cw(12'h000, 32'h33220001);
        chk("span start", 32'h3322, {16'h0, sel_spans[15:0]});
        chk("span end", 32'hbbaa, {16'h0, sel_spans[639:624]});
        cb(80, 8'haa);
        w32(12'h1f4, 32'h1234ffff, `DLS_RESP_OKAY);
        chk("flags", 32'h1234, {16'h0, sel_flags});
        cw(12'h1f4, 32'h12340003);
        w32(12'h1ec, 32'h0, `DLS_RESP_OKAY);
        cw(12'h1ec, 32'h55667788);
        cw(12'h1f0, 32'h11223344);
        w32(12'h1fc, 32'h0000beef, `DLS_RESP_OKAY);
        chk("pending", 32'hbeef, {16'h0, sel_pending});
        cb(508, 8'hef);
        cb(509, 8'hbe);
        sumchk();
        pick(2'h3, 6'h02);
        cw(`DLS_ADDR_SEL, 32'h00000203);
        cw(12'h1fc, 32'h0);
        pick(dls_pkg::DLS_LOG_ERR, 6'h02);
        cw(12'h1fc, 32'h0);
        w32(12'h208, 32'h0, `DLS_RESP_SLVERR);
        r32(12'h208, d, `DLS_RESP_SLVERR);
        chk("unmapped data", 32'h0, d);
        err_event <= 1'b1;
        repeat (65540) @(posedge clock);
        err_event <= 1'b0;
        @(posedge clock);
        r32(`DLS_ADDR_STATUS, d, `DLS_RESP_OKAY);
        chk("error count", 32'hffff, {16'h0, d[31:16]});
        stop_test();
    end
endmodule // dls_top_bench

/* File: src/dls_defs.svh */
// offsets, field positions, fixed values and sizes for the log sector builder
`ifndef DLS_DEFS_SVH
`define DLS_DEFS_SVH
`define DLS_ADDR_SEL 12'h200
`define DLS_ADDR_STATUS 12'h204
`define DLS_WIN_LAST 12'h1fc
`define DLS_SEL_KIND_LSB 0
`define DLS_SEL_SECT_LSB 8
`define DLS_ERR_VERSION 8'h01
`define DLS_ERR_VER_BYTE 9'd0
`define DLS_ERR_IDX_BYTE 9'd1
`define DLS_ERR_ENT_BASE 9'd2
`define DLS_ERR_ENT_LEN 9'd90
`define DLS_ERR_ENT_END 9'd452
`define DLS_ERR_CNT_LO 9'd452
`define DLS_ERR_CNT_HI 9'd453
`define DLS_ERR_PER_SECT 5
`define DLS_ERR_WORD_BYTES 9'd4
`define DLS_ST_REV 16'h0001
`define DLS_ST_DESC_BASE 9'd2
`define DLS_ST_DESC_LEN 9'd24
`define DLS_ST_DESC_END 9'd506
`define DLS_ST_DESC_USED 9'd9
`define DLS_ST_NDESC 21
`define DLS_ST_IDX_BYTE 9'd508
`define DLS_SEL_WR_END 9'd82
`define DLS_SEL_CUR_LBA 9'd492
`define DLS_SEL_CUR_SPAN 9'd500
`define DLS_SEL_FLAGS 9'd502
`define DLS_SEL_PEND 9'd508
`define DLS_CKSUM_BYTE 9'd511
`define DLS_RESP_OKAY 2'h0
`define DLS_RESP_SLVERR 2'h2
`endif

/* File: src/dls_pkg.sv */
// shared types of the log sector builder
package dls_pkg;
    typedef enum logic [1:0] {DLS_LOG_ERR, DLS_LOG_ST, DLS_LOG_SEL, DLS_LOG_NONE} dls_log_e;
    typedef logic [7:0] dls_byte_t;
endpackage

/* File: src/dls_top.sv */
// diagnostic log sector builder with an axi4-lite window onto each 512-byte sector
// Summary of operation
// R1: error log version byte is 01h
// R2: error index zero until first error logged
// R3: error index points at newest entry
// R4: two to 51 error sectors, five entries each
// R5: full log wraps to sector zero entry one
// R6: unwritten error entries read all zeros
// R7: self-test sector: revision, 21 descriptors, index, checksum
// R8: descriptors placed circularly from byte 2, stride 24
// R9: unused descriptors read all zeros
// R10: self-test revision reads 0001h
// R11: descriptor byte layout, multi-byte fields low first
// R12: subcommand byte at issue, status at completion
// R13: lifetime hours captured at test completion
// R14: failing address holds first uncorrectable sector
// R15: self-test index 0, then 1..21 wrapping
// R16: byte 511 makes sector sum zero
// R17: host writes five start/end spans from byte 2
// R18: current address and span are read-only
// R19: flags and pending time host writable
// R20: selective revision returned as written
// R21: first error sector field placement
// R22: error count saturates at maximum
// R23: checksum recomputed before every read
`timescale 1ns/1ps
`include "dls_defs.svh"
module dls_top #(
    parameter int NSECT = 2,
    parameter int ADDR_W = 12
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic err_event,
    input wire logic [31:0] err_record,
    input wire logic st_issue,
    input wire logic [7:0] st_lba_low,
    input wire logic st_done,
    input wire logic [7:0] st_status,
    input wire logic [7:0] st_checkpoint,
    input wire logic [31:0] st_fail_lba,
    input wire logic [15:0] power_hours,
    input wire logic [63:0] cur_test_lba,
    input wire logic [15:0] cur_test_span,
    output logic [639:0] sel_spans,
    output logic [15:0] sel_flags,
    output logic [15:0] sel_pending
);
    localparam int NE = NSECT * `DLS_ERR_PER_SECT;
    localparam int ND = `DLS_ST_NDESC;

    typedef struct packed {
        logic [NE-1:0][31:0] ent;
        logic [NSECT-1:0][7:0] esum;
        logic [7:0] wp;
        logic [7:0] eidx;
        logic [15:0] ecnt;
        logic [ND-1:0][71:0] desc;
        logic [4:0] sp;
        logic [7:0] sidx;
        logic [7:0] ssum;
        logic [7:0] pend_lo;
        logic [81:0][7:0] sel;
        logic [15:0] flags;
        logic [15:0] pend_t;
        logic [1:0] kind;
        logic [5:0] sect;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } dls_state_s;

    dls_state_s st_reg;
    dls_state_s st_next;

    function automatic logic [7:0] sum_bytes(input logic [71:0] v);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 9; i++) begin
            s = s + v[i*8 +: 8];
        end
        return s;
    endfunction

    // selective sector sum taken live, since current address and span change under it
    function automatic logic [7:0] sel_sum(input dls_state_s q);
        logic [7:0] s;
        s = sum_bytes({8'h00, cur_test_lba}) + cur_test_span[7:0] + cur_test_span[15:8];
        s = s + q.flags[7:0] + q.flags[15:8] + q.pend_t[7:0] + q.pend_t[15:8];
        for (int i = 0; i < 82; i++) begin
            s = s + q.sel[i];
        end
        return s;
    endfunction

    function automatic logic [7:0] get_byte(input dls_state_s q, input logic [8:0] o);
        logic [7:0] b;
        logic [8:0] sl;
        logic [8:0] rel;
        logic [7:0] hsum;
        b = 8'h00;
        sl = 9'd0;
        rel = 9'd0;
        hsum = 8'h00;
        case (dls_pkg::dls_log_e'(q.kind))
            dls_pkg::DLS_LOG_ERR: begin
                if (32'(q.sect) < NSECT) begin
                    if (q.sect == 6'h00) begin
                        hsum = `DLS_ERR_VERSION + q.eidx + q.ecnt[7:0] + q.ecnt[15:8];
                        if (o == `DLS_ERR_VER_BYTE) b = `DLS_ERR_VERSION; // [R1] [R21]
                        if (o == `DLS_ERR_IDX_BYTE) b = q.eidx; // [R2] [R21]
                        if (o == `DLS_ERR_CNT_LO) b = q.ecnt[7:0]; // [R21]
                        if (o == `DLS_ERR_CNT_HI) b = q.ecnt[15:8]; // [R21]
                    end
                    if (o >= `DLS_ERR_ENT_BASE && o < `DLS_ERR_ENT_END) begin
                        sl = (o - `DLS_ERR_ENT_BASE) / `DLS_ERR_ENT_LEN;
                        rel = o - `DLS_ERR_ENT_BASE - sl * `DLS_ERR_ENT_LEN;
                        // only the record word is kept; the rest of each entry reads zero
                        if (rel < `DLS_ERR_WORD_BYTES) begin
                            b = q.ent[32'(q.sect) * `DLS_ERR_PER_SECT + 32'(sl)][rel[1:0]*8 +: 8]; // [R6]
                        end
                    end
                    if (o == `DLS_CKSUM_BYTE) b = 8'h00 - (q.esum[q.sect] + hsum); // [R16] [R23]
                end
            end
            dls_pkg::DLS_LOG_ST: begin
                if (q.sect == 6'h00) begin
                    if (o == 9'd0) b = 8'(`DLS_ST_REV); // [R10]
                    if (o == 9'd1) b = 8'(`DLS_ST_REV >> 8); // [R10]
                    if (o >= `DLS_ST_DESC_BASE && o < `DLS_ST_DESC_END) begin
                        sl = (o - `DLS_ST_DESC_BASE) / `DLS_ST_DESC_LEN;
                        rel = o - `DLS_ST_DESC_BASE - sl * `DLS_ST_DESC_LEN;
                        if (rel < `DLS_ST_DESC_USED) b = q.desc[sl][rel*8 +: 8]; // [R7] [R9] [R11]
                    end
                    if (o == `DLS_ST_IDX_BYTE) b = q.sidx; // [R7]
                    if (o == `DLS_CKSUM_BYTE) begin
                        b = 8'h00 - (8'h01 + q.sidx + q.ssum); // [R16] [R23]
                    end
                end
            end
            dls_pkg::DLS_LOG_SEL: begin
                if (q.sect == 6'h00) begin
                    if (o < `DLS_SEL_WR_END) b = q.sel[o]; // [R17] [R20]
                    if (o >= `DLS_SEL_CUR_LBA && o < `DLS_SEL_CUR_SPAN) begin
                        b = cur_test_lba[(o - `DLS_SEL_CUR_LBA)*8 +: 8]; // [R18]
                    end
                    if (o == `DLS_SEL_CUR_SPAN) b = cur_test_span[7:0]; // [R18]
                    if (o == `DLS_SEL_CUR_SPAN + 9'd1) b = cur_test_span[15:8]; // [R18]
                    if (o == `DLS_SEL_FLAGS) b = q.flags[7:0]; // [R19]
                    if (o == `DLS_SEL_FLAGS + 9'd1) b = q.flags[15:8]; // [R19]
                    if (o == `DLS_SEL_PEND) b = q.pend_t[7:0]; // [R19]
                    if (o == `DLS_SEL_PEND + 9'd1) b = q.pend_t[15:8]; // [R19]
                    if (o == `DLS_CKSUM_BYTE) b = 8'h00 - sel_sum(q); // [R16] [R23]
                end
            end
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    always_comb begin
        logic [8:0] o;
        logic [7:0] dsec;
        logic [71:0] nd;
        st_next = st_reg;
        o = 9'd0;
        dsec = 8'h00;
        nd = 72'h0;

        // error capture; unused slots stay zero from reset
        if (err_event) begin
            dsec = st_reg.wp / 8'(`DLS_ERR_PER_SECT);
            st_next.ent[st_reg.wp] = err_record;
            st_next.esum[dsec] = st_reg.esum[dsec] - sum_bytes({40'h0, st_reg.ent[st_reg.wp]})
                + sum_bytes({40'h0, err_record}); // [R23]
            st_next.eidx = st_reg.wp + 8'h01; // [R2] [R3]
            st_next.wp = (32'(st_reg.wp) == NE - 1) ? 8'h00 : st_reg.wp + 8'h01; // [R4] [R5]
            if (st_reg.ecnt != 16'hffff) st_next.ecnt = st_reg.ecnt + 16'h0001; // [R22]
        end

        // self-test capture
        if (st_issue) st_next.pend_lo = st_lba_low; // [R12]
        if (st_done) begin
            // failing address is passed through as given; it only means something on a media failure
            nd = {st_fail_lba, st_checkpoint, power_hours, st_status, st_reg.pend_lo}; // [R11] [R12] [R13] [R14]
            st_next.desc[st_reg.sp] = nd; // [R8]
            st_next.ssum = st_reg.ssum - sum_bytes(st_reg.desc[st_reg.sp]) + sum_bytes(nd); // [R23]
            st_next.sidx = {3'h0, st_reg.sp} + 8'h01; // [R15]
            st_next.sp = (st_reg.sp == 5'(ND - 1)) ? 5'h00 : st_reg.sp + 5'h01; // [R8]
        end

        // write channel: address and data accepted in either order
        if (s_axi_awvalid && st_reg.awready) begin
            st_next.awready = 1'b0;
            st_next.aw_got = 1'b1;
            st_next.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_reg.wready) begin
            st_next.wready = 1'b0;
            st_next.w_got = 1'b1;
            st_next.wdata = s_axi_wdata;
            st_next.wstrb = s_axi_wstrb;
        end
        if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = `DLS_RESP_OKAY;
            if (st_reg.waddr == ADDR_W'(`DLS_ADDR_SEL)) begin
                if (st_reg.wstrb[0]) st_next.kind = st_reg.wdata[`DLS_SEL_KIND_LSB +: 2];
                if (st_reg.wstrb[1]) st_next.sect = st_reg.wdata[`DLS_SEL_SECT_LSB +: 6];
            end else if (st_reg.waddr == ADDR_W'(`DLS_ADDR_STATUS)) begin
                st_next.bresp = `DLS_RESP_OKAY;
            end else if (st_reg.waddr <= ADDR_W'(`DLS_WIN_LAST)) begin
                // only the selective sector takes host data; other logs ignore window writes
                if (st_reg.kind == 2'(dls_pkg::DLS_LOG_SEL) && st_reg.sect == 6'h00) begin
                    for (int i = 0; i < 4; i++) begin
                        o = {st_reg.waddr[8:2], 2'(i)};
                        if (st_reg.wstrb[i]) begin
                            if (o < `DLS_SEL_WR_END) st_next.sel[o] = st_reg.wdata[i*8 +: 8]; // [R17] [R20]
                            if (o == `DLS_SEL_FLAGS) st_next.flags[7:0] = st_reg.wdata[i*8 +: 8]; // [R19]
                            if (o == `DLS_SEL_FLAGS + 9'd1) st_next.flags[15:8] = st_reg.wdata[i*8 +: 8]; // [R19]
                            if (o == `DLS_SEL_PEND) st_next.pend_t[7:0] = st_reg.wdata[i*8 +: 8]; // [R19]
                            if (o == `DLS_SEL_PEND + 9'd1) st_next.pend_t[15:8] = st_reg.wdata[i*8 +: 8]; // [R19]
                        end
                    end
                end
            end else begin
                st_next.bresp = `DLS_RESP_SLVERR;
            end
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
            st_next.awready = 1'b1;
            st_next.wready = 1'b1;
        end

        // read channel: one cycle from address to data
        if (s_axi_arvalid && st_reg.arready) begin
            st_next.arready = 1'b0;
            st_next.rvalid = 1'b1;
            st_next.rresp = `DLS_RESP_OKAY;
            st_next.rdata = 32'h0;
            if (s_axi_araddr == ADDR_W'(`DLS_ADDR_SEL)) begin
                st_next.rdata = {16'h0, 2'h0, st_reg.sect, 6'h0, st_reg.kind};
            end else if (s_axi_araddr == ADDR_W'(`DLS_ADDR_STATUS)) begin
                st_next.rdata = {st_reg.ecnt, st_reg.sidx, st_reg.eidx};
            end else if (s_axi_araddr <= ADDR_W'(`DLS_WIN_LAST)) begin
                for (int i = 0; i < 4; i++) begin
                    st_next.rdata[i*8 +: 8] = get_byte(st_reg, {s_axi_araddr[8:2], 2'(i)});
                end
            end else begin
                st_next.rresp = `DLS_RESP_SLVERR;
            end
        end
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
            st_next.arready = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_reg <= '0;
            st_reg.awready <= 1'b1;
            st_reg.wready <= 1'b1;
            st_reg.arready <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready = st_reg.awready;
    assign s_axi_wready = st_reg.wready;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rresp = st_reg.rresp;
    assign s_axi_rdata = st_reg.rdata;
    assign sel_spans = st_reg.sel[81:2];
    assign sel_flags = st_reg.flags;
    assign sel_pending = st_reg.pend_t;

    sequence s_write_held;
        st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
    endsequence
    sequence s_resp_up;
        ##1 s_axi_bvalid;
    endsequence

    a_write_answer: assert property (@(posedge clock) disable iff (sys_rst) // [R19]
        s_write_held |-> s_resp_up) else $error("write response not raised");
    a_read_answer: assert property (@(posedge clock) disable iff (sys_rst)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready) else $error("read data late");
    a_err_index: assert property (@(posedge clock) disable iff (sys_rst) // [R3]
        err_event |=> st_reg.eidx == $past(st_reg.wp) + 8'h01) else $error("error index not newest");
    a_err_wrap: assert property (@(posedge clock) disable iff (sys_rst) // [R5]
        err_event && 32'(st_reg.wp) == NE - 1 |=> st_reg.wp == 8'h00) else $error("error log did not wrap");
    a_idx_empty: assert property (@(posedge clock) disable iff (sys_rst) // [R2]
        st_reg.ecnt == 16'h0 |-> st_reg.eidx == 8'h00) else $error("index set with no error");
    a_cnt_sat: assert property (@(posedge clock) disable iff (sys_rst) // [R22]
        $past(st_reg.ecnt) == 16'hffff |-> st_reg.ecnt == 16'hffff) else $error("error count wrapped");
    a_st_wrap: assert property (@(posedge clock) disable iff (sys_rst) // [R15]
        st_done && st_reg.sidx == 8'd21 |=> st_reg.sidx == 8'd1) else $error("self-test index no wrap");
    a_st_capture: assert property (@(posedge clock) disable iff (sys_rst) // [R12]
        st_done |=> st_reg.desc[$past(st_reg.sp)][7:0] == $past(st_reg.pend_lo)
        && st_reg.desc[$past(st_reg.sp)][15:8] == $past(st_status)) else $error("descriptor capture");
    a_st_hours: assert property (@(posedge clock) disable iff (sys_rst) // [R13]
        st_done |=> st_reg.desc[$past(st_reg.sp)][31:16] == $past(power_hours)) else $error("hours wrong");
    a_err_version: assert property (@(posedge clock) disable iff (sys_rst) // [R1]
        s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_W'(0) && st_reg.kind == 2'h0
        && st_reg.sect == 6'h00 |=> s_axi_rdata[7:0] == `DLS_ERR_VERSION) else $error("version byte");
endmodule // dls_top
